// ==== rtl/ich_consts.vh ====
// Constants for the interrupt controller host-side command port driver.
`ifndef ICH_CONSTS_VH
`define ICH_CONSTS_VH
// Wishbone register word offsets (wb_adr_i bits 5:2).
`define ICH_OFF_INIT1 4'h0
`define ICH_OFF_INIT2 4'h1
`define ICH_OFF_INIT3 4'h2
`define ICH_OFF_INIT4 4'h3
`define ICH_OFF_CMD 4'h4
`define ICH_OFF_MASKW 4'h5
`define ICH_OFF_STATUS 4'h6
`define ICH_OFF_RDATA 4'h7
`define ICH_OFF_ISTAT 4'h8
`define ICH_OFF_ICLR 4'h9
`define ICH_OFF_IEN 4'hA
// Command register opcodes (bits 3:0 of the data written to CMD).
`define ICH_OP_SVC_DONE 4'h1
`define ICH_OP_ROT_SVC_DONE 4'h2
`define ICH_OP_SET_PRIO 4'h3
`define ICH_OP_MASK_MODE 4'h4
`define ICH_OP_POLL 4'h5
`define ICH_OP_RD_REQ 4'h6
`define ICH_OP_RD_INSVC 4'h7
// Command word fixed fields and positions.
`define ICH_INIT1_MARK 8'h10
`define ICH_OC2_SPEC_EOI 3'h3
`define ICH_OC2_ROT_SPEC 3'h7
`define ICH_OC2_SET_PRIO 3'h6
`define ICH_OC3_BASE 8'h08
`define ICH_OC3_SPECIAL_MASK_ENABLE 8'h40
`define ICH_OC3_SMM 8'h20
`define ICH_OC3_POLL 8'h04
`define ICH_OC3_RR 8'h02
`define ICH_OC3_RIS 8'h01
`define ICH_INIT1_IC4_BIT 0
`define ICH_INIT1_SNGL_BIT 1
`define ICH_LVL_ARG_LSB 4
`define ICH_SMM_ARG_BIT 4
`define ICH_PEND_BIT 7
`define ICH_INIT1_KEEP 5'h0B
// Bus cycle phase lengths in clock cycles.
`define ICH_SETUP_CYC 4'h2
`define ICH_STROBE_CYC 4'h4
`define ICH_HOLD_CYC 4'h2
// Status and interrupt bit positions.
`define ICH_ST_BUSY 0
`define ICH_ST_INITED 1
`define ICH_ST_ERR 2
`define ICH_EV_DONE 0
`define ICH_EV_PEND 1
`define ICH_EV_ERR 2
`endif

// ==== rtl/ich_host.v ====
// Host-side driver that programs and polls an eight-input interrupt controller over its parallel port.
//
// Contract
// - Command three bit 7 written zero
// - Poll applies once; reissue per poll
// - Register read follows at same port
// - Init order one, two, three, four
// - Every cascaded controller initialized separately
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "ich_consts.vh"
module ich_host
(
  // System.
  input wire clk,
  input wire rst,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq,
  // Device parallel port.
  output reg dev_cs_n,
  output reg dev_wr_n,
  output reg dev_rd_n,
  output reg dev_port_sel,
  output reg [7:0] dev_d_o,
  output reg dev_d_oe,
  input wire [7:0] dev_d_i
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_HOLD = 2'h3;
  // Init progress: which word is expected next.
  localparam IN_NONE = 3'h0;
  localparam IN_W2 = 3'h1;
  localparam IN_W3 = 3'h2;
  localparam IN_W4 = 3'h3;
  localparam IN_DONE = 3'h4;

  reg [1:0] state_r;
  reg [3:0] cnt_r;
  reg is_read_r;
  reg [2:0] init_r;
  reg need_w3_r;
  reg need_w4_r;
  reg [7:0] rdata_r;
  reg err_r;
  reg [2:0] istat_r;
  reg [2:0] ien_r;
  reg [2:0] ev_set;
  reg acc_ok;
  reg start;
  reg start_rd;
  reg start_port;
  reg [7:0] start_word;
  reg [31:0] rd_mux;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire busy = (state_r != ST_IDLE);
  wire [3:0] op = wb_dat_i[3:0];
  wire [2:0] lvl = wb_dat_i[`ICH_LVL_ARG_LSB+2:`ICH_LVL_ARG_LSB];

  // Builds a level-carrying command two word; level field names input 0..7.
  function [7:0] oc2_word;
    input [2:0] code;
    input [2:0] level;
    begin
      oc2_word = {code, 2'b00, level};
    end
  endfunction

  // Decode a write into one device bus cycle. Cycle-starting writes while busy or out of order are refused and flag an error.
  always @*
  begin
    start = 1'b0;
    start_rd = 1'b0;
    start_port = 1'b0;
    start_word = 8'h00;
    acc_ok = 1'b1;
    if (wb_wr)
    begin
      case (wb_adr_i)
        `ICH_OFF_INIT1:
        begin
          start = 1'b1;
          start_word = `ICH_INIT1_MARK | {3'h0, wb_dat_i[4:0] & `ICH_INIT1_KEEP};
        end
        `ICH_OFF_INIT2:
        begin
          acc_ok = (init_r == IN_W2);
          start = acc_ok;
          start_port = 1'b1;
          start_word = wb_dat_i[7:0];
        end
        `ICH_OFF_INIT3:
        begin
          acc_ok = (init_r == IN_W3);
          start = acc_ok;
          start_port = 1'b1;
          start_word = wb_dat_i[7:0];
        end
        `ICH_OFF_INIT4:
        begin
          acc_ok = (init_r == IN_W4);
          start = acc_ok;
          start_port = 1'b1;
          start_word = {3'h0, wb_dat_i[4:0]};
        end
        `ICH_OFF_MASKW:
        begin
          acc_ok = (init_r == IN_DONE);
          start = acc_ok;
          start_port = 1'b1;
          start_word = wb_dat_i[7:0];
        end
        `ICH_OFF_CMD:
        begin
          acc_ok = (init_r == IN_DONE);
          start = acc_ok;
          case (op)
            `ICH_OP_SVC_DONE: start_word = oc2_word(`ICH_OC2_SPEC_EOI, lvl);
            `ICH_OP_ROT_SVC_DONE: start_word = oc2_word(`ICH_OC2_ROT_SPEC, lvl);
            `ICH_OP_SET_PRIO: start_word = oc2_word(`ICH_OC2_SET_PRIO, lvl);
            // Command three: D7 zero, D4 zero, D3 one.
            `ICH_OP_MASK_MODE: start_word = `ICH_OC3_BASE | `ICH_OC3_SPECIAL_MASK_ENABLE |
              (wb_dat_i[`ICH_SMM_ARG_BIT] ? `ICH_OC3_SMM : 8'h00);
            `ICH_OP_POLL: start_word = `ICH_OC3_BASE | `ICH_OC3_POLL;
            `ICH_OP_RD_REQ: start_word = `ICH_OC3_BASE | `ICH_OC3_RR;
            `ICH_OP_RD_INSVC: start_word = `ICH_OC3_BASE | `ICH_OC3_RR | `ICH_OC3_RIS;
            default:
            begin
              acc_ok = 1'b0;
              start = 1'b0;
            end
          endcase
        end
        `ICH_OFF_RDATA:
        begin
          // Port-0 read that follows a poll or read-register command.
          acc_ok = (init_r == IN_DONE);
          start = acc_ok;
          start_rd = 1'b1;
        end
        default:
        begin
          acc_ok = 1'b1;
        end
      endcase
      if (busy && start)
      begin
        start = 1'b0;
        acc_ok = 1'b0;
      end
    end
  end

  // Readback multiplexer for the register file.
  always @*
  begin
    case (wb_adr_i)
      `ICH_OFF_STATUS: rd_mux = {26'h0, init_r, err_r, init_r == IN_DONE, busy};
      `ICH_OFF_RDATA: rd_mux = {24'h0, rdata_r};
      `ICH_OFF_ISTAT: rd_mux = {29'h0, istat_r};
      `ICH_OFF_IEN: rd_mux = {29'h0, ien_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus slave: one-cycle ack after the request is seen; unmapped addresses read zero.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_mux;
    end
  end

  // Device bus cycle: setup with chip select, strobe low, then hold before release.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      is_read_r <= 1'b0;
      dev_cs_n <= 1'b1;
      dev_wr_n <= 1'b1;
      dev_rd_n <= 1'b1;
      dev_port_sel <= 1'b0;
      dev_d_o <= 8'h00;
      dev_d_oe <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            state_r <= ST_SETUP;
            cnt_r <= `ICH_SETUP_CYC;
            is_read_r <= start_rd;
            dev_cs_n <= 1'b0;
            dev_port_sel <= start_port;
            dev_d_o <= start_word;
            dev_d_oe <= ~start_rd;
          end
        end
        ST_SETUP:
        begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1)
          begin
            state_r <= ST_STROBE;
            cnt_r <= `ICH_STROBE_CYC;
            dev_wr_n <= is_read_r;
            dev_rd_n <= ~is_read_r;
          end
        end
        ST_STROBE:
        begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1)
          begin
            state_r <= ST_HOLD;
            cnt_r <= `ICH_HOLD_CYC;
            dev_wr_n <= 1'b1;
            dev_rd_n <= 1'b1;
            if (is_read_r)
              rdata_r <= dev_d_i;
          end
        end
        ST_HOLD:
        begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1)
          begin
            state_r <= ST_IDLE;
            dev_cs_n <= 1'b1;
            dev_d_oe <= 1'b0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Init sequencing tracks which word is legal next.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      init_r <= IN_NONE;
      need_w3_r <= 1'b0;
      need_w4_r <= 1'b0;
    end
    else if (start)
    begin
      case (wb_adr_i)
        `ICH_OFF_INIT1:
        begin
          init_r <= IN_W2;
          need_w3_r <= ~wb_dat_i[`ICH_INIT1_SNGL_BIT];
          need_w4_r <= wb_dat_i[`ICH_INIT1_IC4_BIT];
        end
        `ICH_OFF_INIT2: init_r <= need_w3_r ? IN_W3 : (need_w4_r ? IN_W4 : IN_DONE);
        `ICH_OFF_INIT3: init_r <= need_w4_r ? IN_W4 : IN_DONE;
        `ICH_OFF_INIT4: init_r <= IN_DONE;
        default: init_r <= init_r;
      endcase
    end
  end

  // Events: cycle done, any port read word with bit 7 set (poll pending), refused access.
  always @*
  begin
    ev_set = 3'h0;
    ev_set[`ICH_EV_DONE] = (state_r == ST_HOLD) && (cnt_r == 4'h1);
    ev_set[`ICH_EV_PEND] = (state_r == ST_STROBE) && (cnt_r == 4'h1) && is_read_r && dev_d_i[`ICH_PEND_BIT];
    ev_set[`ICH_EV_ERR] = wb_wr & ~acc_ok;
  end

  // Sticky status; a set in the same cycle as a clear wins.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      istat_r <= 3'h0;
      ien_r <= 3'h0;
      err_r <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (wb_wr && wb_adr_i == `ICH_OFF_ICLR)
        istat_r <= (istat_r & ~wb_dat_i[2:0]) | ev_set;
      else
        istat_r <= istat_r | ev_set;
      if (wb_wr && wb_adr_i == `ICH_OFF_IEN)
        ien_r <= wb_dat_i[2:0];
      if (ev_set[`ICH_EV_ERR])
        err_r <= 1'b1;
      else if (wb_wr && wb_adr_i == `ICH_OFF_ICLR && wb_dat_i[`ICH_EV_ERR])
        err_r <= 1'b0;
      irq <= |(istat_r & ien_r);
    end
  end

endmodule

// ==== sim/ich_dev_model.sv ====
// Behavioural model of the eight-input interrupt controller at its parallel port.
`timescale 1ns/10ps
module ich_dev_model (
  // Port pins.
  input wire cs_n,
  input wire wr_n,
  input wire rd_n,
  input wire a0,
  input wire [7:0] d_i,
  output wire [7:0] d_o,
  // Requests and write trace.
  input wire [7:0] req,
  input wire inta,
  output reg [8:0] last_w
);
  reg [7:0] request_latch_reg = 8'h00;
  reg [7:0] in_service_reg = 8'h00;
  reg [7:0] q = 8'h00;
  reg poll = 1'b0;
  reg read_target_select = 1'b0;
  reg special_mask_mode = 1'b0;
  integer k;
  integer j;
  initial last_w = 9'h000;
  // Requests stay latched even on masked lines.
  always @(req) request_latch_reg = request_latch_reg | req;
  // Words are decoded by their fixed bits at the trailing edge of the strobe.
  // An acknowledge shares this process so the in-service bits have one writer; the lowest pending level wins.
  always @(posedge wr_n or posedge inta)
    if (inta)
    begin
      for (j = 0; j < 8; j = j + 1)
        if (request_latch_reg[j] && (request_latch_reg & ~(8'hFF << j)) == 8'h00) in_service_reg[j] <= 1'b1;
    end
    else if (!cs_n)
    begin
      last_w <= {a0, d_i};
      if (!a0 && d_i[4])
      begin
        poll <= 1'b0;
        special_mask_mode <= 1'b0;
      end
      else if (!a0 && d_i[3])
      begin
        if (d_i[6]) special_mask_mode <= d_i[5];
        poll <= d_i[2];
        if (d_i[1]) read_target_select <= d_i[0];
      end
      else if (!a0 && d_i[6:5] == 2'b11) in_service_reg[d_i[2:0]] <= 1'b0;
    end
  // Read data is fixed at the leading edge; a released bus shows the inverse, not a held value.
  always @(negedge rd_n)
    if (!cs_n)
    begin
      q = poll ? {|request_latch_reg, 7'h00} : (read_target_select ? in_service_reg : request_latch_reg);
      for (k = 7; k >= 0; k = k - 1)
        if (poll && request_latch_reg[k]) q[2:0] = k[2:0];
    end
  // A poll serves one read only.
  always @(posedge rd_n) if (!cs_n) poll <= 1'b0;
  assign d_o = (!cs_n && !rd_n) ? q : ~q;
endmodule

// ==== sim/ich_host_sva.sv ====
// Port checker for the interrupt controller host driver.
`timescale 1ns/10ps
module ich_host_sva (
  // System.
  input wire clk,
  input wire rst,
  // Bus.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Device port.
  input wire dev_cs_n,
  input wire dev_wr_n,
  input wire dev_rd_n,
  input wire dev_port_sel,
  input wire [7:0] dev_d_o,
  input wire dev_d_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A write on port zero with these fixed bits is a command word.
  wire oc_w = !dev_cs_n && dev_d_oe && !dev_port_sel;
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_strobe_cs: assert property (!dev_wr_n || !dev_rd_n |-> !dev_cs_n) else $error("strobe outside select");
  a_oe_write: assert property (dev_d_oe |-> dev_rd_n) else $error("drive during read");
  a_cs_lead: assert property ($fell(dev_cs_n) |-> ##2 (!dev_wr_n || !dev_rd_n)) else $error("strobe lead");
  a_wr_len: assert property ($fell(dev_wr_n) |-> !dev_wr_n [*4] ##1 dev_wr_n) else $error("strobe length");
  a_data_hold: assert property (!dev_wr_n |-> dev_d_oe && $stable(dev_d_o)) else $error("data moved");
  a_oc3_fixed: assert property (oc_w && dev_d_o[4:3] == 2'b01 |-> !dev_d_o[7]) else $error("bit 7 set");
  a_oc2_code: assert property (oc_w && dev_d_o[4:3] == 2'b00 |-> dev_d_o[7:5] inside {3'h3, 3'h7, 3'h6})
    else $error("bad code");
  c_read: cover property ($fell(dev_rd_n));
  c_oc3: cover property (oc_w && dev_d_o[4:3] == 2'b01);
  c_init: cover property (oc_w && dev_d_o[4]);
endmodule
bind ich_host ich_host_sva ich_host_sva_i (.*);

// ==== sim/ich_host_tb.sv ====
// Self-checking bench for the interrupt controller host driver.
`timescale 1ns/10ps
module ich_host_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [31:0] dat = 32'h0;
  reg [7:0] req = 8'h00;
  reg inta = 1'b0;
  wire [31:0] dat_o;
  wire ack, irq, cs_n, wr_n, rd_n, a0, oe;
  wire [7:0] d_o, d_i;
  wire [8:0] last_w;
  integer bad_count = 0;
  integer comparisons = 0;
  integer i;
  logic [31:0] q;
  // Rows: command written, word seen at the device, read expected (bit 8 marks a read).
  logic [7:0] op_t [8] = '{8'h07, 8'h06, 8'h05, 8'h14, 8'h04, 8'h21, 8'h32, 8'h73};
  logic [7:0] w_t [8] = '{8'h0B, 8'h0A, 8'h0C, 8'h68, 8'h48, 8'h62, 8'hE3, 8'hC7};
  logic [8:0] r_t [8] = '{9'h104, 9'h124, 9'h182, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0};
  always #5 clk = ~clk;
  ich_host ich_host_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .dev_cs_n(cs_n),
    .dev_wr_n(wr_n), .dev_rd_n(rd_n), .dev_port_sel(a0), .dev_d_o(d_o), .dev_d_oe(oe), .dev_d_i(d_i));
  ich_dev_model ich_dev_model_i (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .a0(a0), .d_i(d_o), .d_o(d_i),
    .req(req), .inta(inta), .last_w(last_w));
  // Comparison with case inequality so unknowns fail.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask
  // One classic bus cycle; the request is held until ack is sampled high, and only the watchdog ends a wait.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1)
        @(posedge clk);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Polls the busy flag, bounded so a stuck flag cannot hang the run.
  task idle;
    integer n;
    begin
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 100)
      begin
        wb(1'b0, 4'h6, 32'h0);
        n = n + 1;
      end
      chk(q[0], 0); // A flag still busy at the limit counts as a mismatch.
    end
  endtask
  task finish_test;
    $display("mismatches=%0d compares=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // The run needs well under a thousand cycles; the watchdog allows five thousand.
  initial
  begin
    #50000;
    bad_count = bad_count + 1;
    finish_test;
  end
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk(irq, 0);
    chk(cs_n, 1);
    wb(1'b1, 4'hA, 32'h1);
    wb(1'b1, 4'h4, 32'h5);
    wb(1'b0, 4'h6, 32'h0);
    chk(q[2], 1);
    chk(last_w, 9'h000);
    wb(1'b1, 4'h0, 32'h2);
    idle;
    chk(last_w, 9'h012);
    wb(1'b1, 4'h1, 32'h20);
    idle;
    chk(last_w, 9'h120);
    chk(irq, 1);
    wb(1'b1, 4'h9, 32'h7);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[2:0], 0);
    chk(irq, 0);
    req <= 8'h24;
    @(posedge clk);
    inta <= 1'b1;
    @(posedge clk);
    inta <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      wb(1'b1, 4'h4, {24'h0, op_t[i]});
      idle;
      chk(last_w, {1'b0, w_t[i]});
      if (r_t[i][8])
      begin
        wb(1'b1, 4'h7, 32'h0);
        idle;
        wb(1'b0, 4'h7, 32'h0);
        chk(q[7:0], r_t[i][7:0]);
      end
    end
    wb(1'b1, 4'h7, 32'h0);
    idle;
    wb(1'b0, 4'h7, 32'h0);
    chk(q[7:0], 8'h24);
    wb(1'b1, 4'h9, 32'h7);
    wb(1'b1, 4'h4, 32'hF);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[2], 1);
    chk(cs_n, 1);
    wb(1'b0, 4'hF, 32'h0);
    chk(q, 0);
    // A poll that serves one read only, then in-service readback after the level-two service-done row.
    wb(1'b1, 4'h4, 32'h7);
    idle;
    wb(1'b1, 4'h4, 32'h5);
    idle;
    for (i = 0; i < 2; i = i + 1)
    begin
      wb(1'b1, 4'h7, 32'h0);
      idle;
      wb(1'b0, 4'h7, 32'h0);
      chk(q[7:0], (i == 0) ? 8'h82 : 8'h00);
    end
    wb(1'b0, 4'h8, 32'h0);
    chk(q[2:0], 3'h7);
    chk(irq, 1);
    // Reset in mid-run: the port returns to idle and the init sequence starts over.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(cs_n, 1);
    chk(irq, 0);
    wb(1'b0, 4'h6, 32'h0);
    chk(q, 0);
    wb(1'b1, 4'h3, 32'h1);
    wb(1'b1, 4'h0, 32'h1);
    idle;
    chk(last_w, 9'h011);
    wb(1'b1, 4'h1, 32'h28);
    idle;
    chk(last_w, 9'h128);
    wb(1'b1, 4'h2, 32'h5);
    idle;
    chk(last_w, 9'h105);
    wb(1'b1, 4'h3, 32'hE3);
    idle;
    chk(last_w, 9'h103);
    // A second port write while the first is still on the bus must be refused.
    wb(1'b1, 4'h5, 32'hFB);
    wb(1'b1, 4'h5, 32'h00);
    idle;
    chk(last_w, 9'h1FB);
    wb(1'b0, 4'h6, 32'h0);
    chk(q, 32'h26);
    finish_test;
  end
endmodule
